//--- logic/jtdr_top.v
// Purpose: test access port data registers, instruction decode and scan cells
// Assumes: test pins are asynchronous to CORE_CLK_IN and sampled; tck far slower than clock
// Notes: tck edges are found by sampling, so tdo changes a few clocks after the falling edge
`timescale 1ns/1ps
`include "jtdr_defs.vh"
module jtdr_top #(
	parameter C0_IN = 52,
	parameter VERSION = 4'h0, // arbitrary
	parameter PART_NUMBER = 16'h1234, // arbitrary
	parameter MAKER_ID = 11'h055 // arbitrary
) (
	input wire CORE_CLK_IN,
	input wire RST_IN,
	input wire CE_IN,
	input wire TCK_IN,
	input wire TMS_IN,
	input wire TDI_IN,
	input wire TEST_RESET_N_IN,
	output reg TDO_OUT,
	output reg TDO_OE_OUT,
	input wire EXT_CHAIN_SERIAL_IN_IN,
	output reg EXT_CHAIN_SERIAL_OUT_OUT,
	output reg [3:0] ACTIVE_CHAIN_NUMBER_OUT,
	output reg [3:0] CURRENT_INSTRUCTION_OUT,
	output reg [3:0] CONTROLLER_STATE_OUT,
	output reg TEST_CLOCK_PHASE_ONE_OUT,
	output reg TEST_CLOCK_PHASE_TWO_OUT,
	output reg CLAMP_OUTPUTS_DISABLED_OUT,
	output reg RESYNC_REQUEST_OUT,
	input wire [C0_IN-1:0] C0_SYS_IN,
	input wire [`JTDR_CHAIN0_LEN-C0_IN-1:0] C0_CORE_IN,
	output reg [C0_IN-1:0] C0_CORE_OUT,
	output reg [`JTDR_CHAIN0_LEN-C0_IN-1:0] C0_SYS_OUT,
	input wire [`JTDR_CHAIN1_LEN-1:0] C1_SYS_IN,
	output reg [`JTDR_CHAIN1_LEN-1:0] C1_CORE_OUT,
	output reg [`JTDR_CHAIN2_LEN-1:0] C2_DATA_OUT,
	output reg C2_UPDATE_OUT
);
	localparam N0 = `JTDR_CHAIN0_LEN;
	localparam N1 = `JTDR_CHAIN1_LEN;
	localparam N2 = `JTDR_CHAIN2_LEN;
	localparam NO = N0 - C0_IN;
	reg [2:0] tck_s_reg;
	reg [1:0] tms_s_reg;
	reg [1:0] tdi_s_reg;
	reg [1:0] trst_s_reg;
	reg [1:0] ext_s_reg;
	reg [3:0] st_reg;
	reg [3:0] st_next;
	reg [3:0] ir_sh_reg;
	reg [3:0] ir_reg;
	reg [3:0] chsel_sh_reg;
	reg [3:0] chain_reg;
	reg bypass_bit_reg;
	reg [31:0] identity_reg;
	reg [N0-1:0] c0_reg;
	reg [N1-1:0] c1_reg;
	reg [N2-1:0] c2_reg;
	wire tck_rise = tck_s_reg[1] & ~tck_s_reg[2];
	wire tck_fall = ~tck_s_reg[1] & tck_s_reg[2];
	wire trst_n = trst_s_reg[1];
	wire tms = tms_s_reg[1];
	wire tdi = tdi_s_reg[1];
	wire [31:0] id_code = {VERSION, PART_NUMBER, MAKER_ID, `JTDR_ID_ONE_BIT};
	wire in_shdr = (st_reg == `JTDR_ST_SHDR);
	wire in_capdr = (st_reg == `JTDR_ST_CAPDR);
	wire in_updr = (st_reg == `JTDR_ST_UPDR);
	wire in_shir = (st_reg == `JTDR_ST_SHIR);
	wire fifo_valid;
	wire fifo_ready;
	wire fifo_data;
	wire cap_ready;

	// path select: 0 bypass 1 identity 2 chain select 3 scan chains
	function [1:0] jtdr_path;
		input [3:0] op;
		begin
			case (op)
				`JTDR_OP_IDENT: jtdr_path = 2'h1;
				`JTDR_OP_SCANSEL: jtdr_path = 2'h2;
				`JTDR_OP_EXTEST, `JTDR_OP_INTEST: jtdr_path = 2'h3;
				default: jtdr_path = 2'h0;
			endcase
		end
	endfunction

	function jtdr_is_ext;
		input [3:0] ch;
		begin
			jtdr_is_ext = (ch != `JTDR_CH_CORE) && (ch != `JTDR_CH_DEBUG) && (ch != `JTDR_CH_MONITOR);
		end
	endfunction

	wire [1:0] path = jtdr_path(ir_reg);
	wire intest = (ir_reg == `JTDR_OP_INTEST);
	wire extest = (ir_reg == `JTDR_OP_EXTEST) || (ir_reg == `JTDR_OP_CLAMP) || (ir_reg == `JTDR_OP_CLAMP_OUTPUTS_DISABLED);

	always @*
	begin
		st_next = st_reg;
		case (st_reg)
			`JTDR_ST_RESET: st_next = tms ? `JTDR_ST_RESET : `JTDR_ST_IDLE;
			`JTDR_ST_IDLE: st_next = tms ? `JTDR_ST_SELDR : `JTDR_ST_IDLE;
			`JTDR_ST_SELDR: st_next = tms ? `JTDR_ST_SELIR : `JTDR_ST_CAPDR;
			`JTDR_ST_CAPDR: st_next = tms ? `JTDR_ST_EX1DR : `JTDR_ST_SHDR;
			`JTDR_ST_SHDR: st_next = tms ? `JTDR_ST_EX1DR : `JTDR_ST_SHDR;
			`JTDR_ST_EX1DR: st_next = tms ? `JTDR_ST_UPDR : `JTDR_ST_PADR;
			`JTDR_ST_PADR: st_next = tms ? `JTDR_ST_EX2DR : `JTDR_ST_PADR;
			`JTDR_ST_EX2DR: st_next = tms ? `JTDR_ST_UPDR : `JTDR_ST_SHDR;
			`JTDR_ST_UPDR: st_next = tms ? `JTDR_ST_SELDR : `JTDR_ST_IDLE;
			`JTDR_ST_SELIR: st_next = tms ? `JTDR_ST_RESET : `JTDR_ST_CAPIR;
			`JTDR_ST_CAPIR: st_next = tms ? `JTDR_ST_EX1IR : `JTDR_ST_SHIR;
			`JTDR_ST_SHIR: st_next = tms ? `JTDR_ST_EX1IR : `JTDR_ST_SHIR;
			`JTDR_ST_EX1IR: st_next = tms ? `JTDR_ST_UPIR : `JTDR_ST_PAIR;
			`JTDR_ST_PAIR: st_next = tms ? `JTDR_ST_EX2IR : `JTDR_ST_PAIR;
			`JTDR_ST_EX2IR: st_next = tms ? `JTDR_ST_UPIR : `JTDR_ST_SHIR;
			`JTDR_ST_UPIR: st_next = tms ? `JTDR_ST_SELDR : `JTDR_ST_IDLE;
			default: st_next = `JTDR_ST_RESET;
		endcase
	end

	// serial data selected for tdo, taken at the fall so the rise has already shifted
	reg sel_bit;
	always @*
	begin
		sel_bit = bypass_bit_reg;
		if (in_shir)
			sel_bit = ir_sh_reg[0];
		else
			case (path)
				2'h1: sel_bit = identity_reg[0];
				2'h2: sel_bit = chsel_sh_reg[0];
				2'h3:
					case (chain_reg)
						`JTDR_CH_CORE: sel_bit = c0_reg[0];
						`JTDR_CH_DEBUG: sel_bit = c1_reg[0];
						`JTDR_CH_MONITOR: sel_bit = c2_reg[0];
						default: sel_bit = ext_s_reg[1];
					endcase
				default: sel_bit = bypass_bit_reg;
			endcase
	end

	// synchronisers; test reset is only sampled, so it needs a running clock
	always @(posedge CORE_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			tck_s_reg <= 3'h0;
			tms_s_reg <= 2'h3;
			tdi_s_reg <= 2'h3;
			trst_s_reg <= 2'h0;
			ext_s_reg <= 2'h0;
		end
		else if (CE_IN)
		begin
			tck_s_reg <= {tck_s_reg[1:0], TCK_IN};
			tms_s_reg <= {tms_s_reg[0], TMS_IN};
			tdi_s_reg <= {tdi_s_reg[0], TDI_IN};
			trst_s_reg <= {trst_s_reg[0], TEST_RESET_N_IN};
			ext_s_reg <= {ext_s_reg[0], EXT_CHAIN_SERIAL_IN_IN};
		end
	end

	always @(posedge CORE_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			st_reg <= `JTDR_ST_RESET;
			ir_sh_reg <= `JTDR_IR_CAPTURE;
			ir_reg <= `JTDR_OP_IDENT;
			chsel_sh_reg <= `JTDR_CHSEL_CAPTURE;
			chain_reg <= `JTDR_CHSEL_RESET;
			bypass_bit_reg <= 1'b0;
			identity_reg <= 32'h0;
			c0_reg <= {N0{1'b0}};
			c1_reg <= {N1{1'b0}};
			c2_reg <= {N2{1'b0}};
			C2_DATA_OUT <= {N2{1'b0}};
			C2_UPDATE_OUT <= 1'b0;
			RESYNC_REQUEST_OUT <= 1'b0;
		end
		else if (CE_IN)
		begin
			C2_UPDATE_OUT <= 1'b0;
			RESYNC_REQUEST_OUT <= 1'b0;
			if (!trst_n)
			begin
				st_reg <= `JTDR_ST_RESET;
				ir_reg <= `JTDR_OP_IDENT;
				chain_reg <= `JTDR_CHSEL_RESET;
			end
			else if (tck_rise)
			begin
				st_reg <= st_next;
				if (st_reg == `JTDR_ST_RESET)
				begin
					ir_reg <= `JTDR_OP_IDENT;
					chain_reg <= `JTDR_CHSEL_RESET;
				end
				if (st_reg == `JTDR_ST_IDLE && jtdr_path(ir_reg) == 2'h0 && ir_reg == `JTDR_OP_RESTART)
					RESYNC_REQUEST_OUT <= 1'b1;
				if (st_reg == `JTDR_ST_CAPIR)
					ir_sh_reg <= `JTDR_IR_CAPTURE;
				if (in_shir)
					ir_sh_reg <= {tdi, ir_sh_reg[3:1]};
				if (st_reg == `JTDR_ST_UPIR)
					ir_reg <= ir_sh_reg;
				if (in_capdr)
					case (path)
						2'h1: identity_reg <= id_code;
						2'h2: chsel_sh_reg <= `JTDR_CHSEL_CAPTURE;
						2'h3:
						begin
							// input cells take system input, output cells take core output
							if (chain_reg == `JTDR_CH_CORE)
								c0_reg <= {C0_CORE_IN, C0_SYS_IN};
							if (chain_reg == `JTDR_CH_DEBUG)
								c1_reg <= C1_SYS_IN;
						end
						default: bypass_bit_reg <= 1'b0;
					endcase
				if (in_shdr)
					case (path)
						2'h1: identity_reg <= {tdi, identity_reg[31:1]};
						2'h2: chsel_sh_reg <= {tdi, chsel_sh_reg[3:1]};
						2'h3:
						begin
							if (chain_reg == `JTDR_CH_CORE)
								c0_reg <= {tdi, c0_reg[N0-1:1]};
							if (chain_reg == `JTDR_CH_DEBUG)
								c1_reg <= {tdi, c1_reg[N1-1:1]};
							if (chain_reg == `JTDR_CH_MONITOR)
								c2_reg <= {tdi, c2_reg[N2-1:1]};
						end
						default: bypass_bit_reg <= tdi;
					endcase
				if (in_updr && path == 2'h2)
					chain_reg <= chsel_sh_reg;
				if (in_updr && path == 2'h3 && chain_reg == `JTDR_CH_MONITOR)
				begin
					C2_DATA_OUT <= c2_reg;
					C2_UPDATE_OUT <= 1'b1;
				end
			end
		end
	end

	// tdo bit is queued at the falling edge while shifting and leaves one clock later
	jtdr_fifo #(.WIDTH(1), .DEPTH(8), .AW(3)) u_fifo (
		.clk_in(CORE_CLK_IN),
		.rst_in(RST_IN),
		.ce_in(CE_IN),
		.in_valid_in(tck_fall && trst_n && (in_shdr || in_shir)),
		.in_ready_out(cap_ready),
		.in_data_in(sel_bit),
		.out_valid_out(fifo_valid),
		.out_ready_in(1'b1),
		.out_data_out(fifo_data)
	);

	always @(posedge CORE_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			TDO_OUT <= 1'b0;
			TDO_OE_OUT <= 1'b0;
			EXT_CHAIN_SERIAL_OUT_OUT <= 1'b0;
			ACTIVE_CHAIN_NUMBER_OUT <= `JTDR_CHSEL_RESET;
			CURRENT_INSTRUCTION_OUT <= `JTDR_OP_IDENT;
			CONTROLLER_STATE_OUT <= `JTDR_ST_RESET;
			TEST_CLOCK_PHASE_ONE_OUT <= 1'b0;
			TEST_CLOCK_PHASE_TWO_OUT <= 1'b0;
			CLAMP_OUTPUTS_DISABLED_OUT <= 1'b0;
			C0_CORE_OUT <= {C0_IN{1'b0}};
			C0_SYS_OUT <= {NO{1'b0}};
			C1_CORE_OUT <= {N1{1'b0}};
		end
		else if (CE_IN)
		begin
			// the queue only fills on a fall, so tdo never moves in the high phase
			if (fifo_valid)
			begin
				TDO_OUT <= fifo_data;
				TDO_OE_OUT <= 1'b1;
			end
			else if (tck_fall && !(in_shdr || in_shir))
				TDO_OE_OUT <= 1'b0;
			EXT_CHAIN_SERIAL_OUT_OUT <= tdi;
			ACTIVE_CHAIN_NUMBER_OUT <= chain_reg;
			CURRENT_INSTRUCTION_OUT <= ir_reg;
			CONTROLLER_STATE_OUT <= st_reg;
			TEST_CLOCK_PHASE_ONE_OUT <= tck_s_reg[1];
			TEST_CLOCK_PHASE_TWO_OUT <= ~tck_s_reg[1];
			// bus, data and control group tristates off for clamp-outputs-disabled and high-z, not plain clamp
			CLAMP_OUTPUTS_DISABLED_OUT <= (ir_reg == `JTDR_OP_CLAMP_OUTPUTS_DISABLED) || (ir_reg == `JTDR_OP_HIGHZ);
			// no update latch, so muxed values ripple while shifting
			C0_CORE_OUT <= (intest && chain_reg == `JTDR_CH_CORE) ? c0_reg[C0_IN-1:0] : C0_SYS_IN;
			C0_SYS_OUT <= (extest && chain_reg == `JTDR_CH_CORE) ? c0_reg[N0-1:C0_IN] : C0_CORE_IN;
			C1_CORE_OUT <= (intest && chain_reg == `JTDR_CH_DEBUG) ? c1_reg : C1_SYS_IN;
		end
	end
endmodule

//--- logic/jtdr_defs.vh
// Purpose: constants for the test access port data registers
// Assumes: 4-bit instructions, 4-bit chain numbers
// Notes: definitions only
`ifndef JTDR_DEFS_VH
`define JTDR_DEFS_VH
`define JTDR_OP_EXTEST 4'h0
`define JTDR_OP_SCANSEL 4'h2
`define JTDR_OP_SAMPLE 4'h3
`define JTDR_OP_RESTART 4'h4
`define JTDR_OP_CLAMP 4'h5
`define JTDR_OP_HIGHZ 4'h7
`define JTDR_OP_CLAMP_OUTPUTS_DISABLED 4'h9
`define JTDR_OP_INTEST 4'hc
`define JTDR_OP_IDENT 4'he
`define JTDR_OP_BYPASS 4'hf
`define JTDR_IR_CAPTURE 4'h1
`define JTDR_CHSEL_CAPTURE 4'h8
`define JTDR_CHSEL_RESET 4'h3
`define JTDR_CH_CORE 4'h0
`define JTDR_CH_DEBUG 4'h1
`define JTDR_CH_MONITOR 4'h2
`define JTDR_CHAIN0_LEN 105
`define JTDR_CHAIN1_LEN 33
`define JTDR_CHAIN2_LEN 38
`define JTDR_ID_ONE_BIT 1'b1
`define JTDR_ST_RESET 4'hf
`define JTDR_ST_IDLE 4'hc
`define JTDR_ST_SELDR 4'h7
`define JTDR_ST_CAPDR 4'h6
`define JTDR_ST_SHDR 4'h2
`define JTDR_ST_EX1DR 4'h1
`define JTDR_ST_PADR 4'h3
`define JTDR_ST_EX2DR 4'h0
`define JTDR_ST_UPDR 4'h5
`define JTDR_ST_SELIR 4'h4
`define JTDR_ST_CAPIR 4'he
`define JTDR_ST_SHIR 4'ha
`define JTDR_ST_EX1IR 4'h9
`define JTDR_ST_PAIR 4'hb
`define JTDR_ST_EX2IR 4'h8
`define JTDR_ST_UPIR 4'hd
`endif

//--- logic/jtdr_fifo.v
// Purpose: small flip-flop fifo
// Assumes: single clock, depth a power of two
// Notes: valid/ready on both sides
`timescale 1ns/1ps
module jtdr_fifo #(
	parameter WIDTH = 1,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk_in,
	input wire rst_in,
	input wire ce_in,
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [WIDTH-1:0] in_data_in,
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW:0] wr_reg;
	reg [AW:0] rd_reg;
	wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
	wire empty = (wr_reg == rd_reg);
	wire do_wr = ce_in && in_valid_in && !full;
	wire do_rd = ce_in && out_ready_in && !empty;
	assign in_ready_out = !full;
	assign out_valid_out = !empty;
	assign out_data_out = mem_reg[rd_reg[AW-1:0]];
	always @(posedge clk_in)
	begin
		if (do_wr)
			mem_reg[wr_reg[AW-1:0]] <= in_data_in;
	end
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wr_reg <= {(AW+1){1'b0}};
			rd_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (do_wr)
				wr_reg <= wr_reg + 1'b1;
			if (do_rd)
				rd_reg <= rd_reg + 1'b1;
		end
	end
endmodule

//--- verif/jtdr_checker.sv
// Purpose: concurrent checks on the test port outputs
// Assumes: test pins are sampled by CORE_CLK_IN
// Notes: bound to jtdr_top
`timescale 1ns/1ps
module jtdr_checker (
	input wire CORE_CLK_IN,
	input wire RST_IN,
	input wire TCK_IN,
	input wire TEST_RESET_N_IN,
	input wire TDO_OUT,
	input wire [3:0] ACTIVE_CHAIN_NUMBER_OUT,
	input wire [3:0] CURRENT_INSTRUCTION_OUT,
	input wire [3:0] CONTROLLER_STATE_OUT,
	input wire TEST_CLOCK_PHASE_ONE_OUT,
	input wire TEST_CLOCK_PHASE_TWO_OUT,
	input wire CLAMP_OUTPUTS_DISABLED_OUT,
	input wire RESYNC_REQUEST_OUT
);
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);
	a_clamp_from_code:
	assert property ($stable(CURRENT_INSTRUCTION_OUT) [*2] |-> CLAMP_OUTPUTS_DISABLED_OUT ==
		(CURRENT_INSTRUCTION_OUT == 4'h9 || CURRENT_INSTRUCTION_OUT == 4'h7)) else $error("clamp wrong");
	a_resync_one_clock:
	assert property (RESYNC_REQUEST_OUT |=> !RESYNC_REQUEST_OUT) else $error("resync too long");
	a_resync_restart_only:
	assert property (RESYNC_REQUEST_OUT |-> CURRENT_INSTRUCTION_OUT == 4'h4) else $error("stray resync");
	a_chain_by_select:
	assert property ($changed(ACTIVE_CHAIN_NUMBER_OUT) && ACTIVE_CHAIN_NUMBER_OUT != 4'h3
		|-> CURRENT_INSTRUCTION_OUT == 4'h2) else $error("chain moved");
	a_test_reset_home:
	assert property (!TEST_RESET_N_IN [*5] |-> CONTROLLER_STATE_OUT == 4'hf && CURRENT_INSTRUCTION_OUT == 4'he
		&& ACTIVE_CHAIN_NUMBER_OUT == 4'h3) else $error("test reset ignored");
	a_phase_follows_tck:
	assert property (TCK_IN [*5] |-> TEST_CLOCK_PHASE_ONE_OUT && !TEST_CLOCK_PHASE_TWO_OUT)
		else $error("phase outputs wrong");
	a_state_waits_rise:
	assert property ((!TCK_IN && TEST_RESET_N_IN) [*5] |=> $stable(CONTROLLER_STATE_OUT))
		else $error("state moved without rise");
	a_tdo_after_fall:
	assert property ($changed(TDO_OUT) && TEST_RESET_N_IN |-> $past(TCK_IN, 2) == 1'b0)
		else $error("tdo moved in high phase");
	a_ir_on_update:
	assert property ($changed(CURRENT_INSTRUCTION_OUT) && TEST_RESET_N_IN |-> CONTROLLER_STATE_OUT == 4'hd
		|| $past(CONTROLLER_STATE_OUT) == 4'hd || $past(CONTROLLER_STATE_OUT, 2) == 4'hd)
		else $error("instruction changed outside update");
	c_resync: cover property (RESYNC_REQUEST_OUT);
	c_chain_zero: cover property (ACTIVE_CHAIN_NUMBER_OUT == 4'h0);
	c_clamp: cover property (CLAMP_OUTPUTS_DISABLED_OUT);
endmodule
bind jtdr_top jtdr_checker u_chk (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .TCK_IN(TCK_IN),
	.TEST_RESET_N_IN(TEST_RESET_N_IN), .TDO_OUT(TDO_OUT), .ACTIVE_CHAIN_NUMBER_OUT(ACTIVE_CHAIN_NUMBER_OUT),
	.CURRENT_INSTRUCTION_OUT(CURRENT_INSTRUCTION_OUT), .CONTROLLER_STATE_OUT(CONTROLLER_STATE_OUT),
	.TEST_CLOCK_PHASE_ONE_OUT(TEST_CLOCK_PHASE_ONE_OUT), .TEST_CLOCK_PHASE_TWO_OUT(TEST_CLOCK_PHASE_TWO_OUT),
	.CLAMP_OUTPUTS_DISABLED_OUT(CLAMP_OUTPUTS_DISABLED_OUT), .RESYNC_REQUEST_OUT(RESYNC_REQUEST_OUT));

//--- verif/jtdr_host.sv
// Purpose: serial test host on the test clock
// Assumes: tck period 800 ns, unrelated to the core clock
// Notes: tdo taken just before each rise, after the fall that set it
`timescale 1ns/1ps
module jtdr_host (
	output reg tck_out,
	output reg tms_out,
	output reg tdi_out,
	input wire tdo_in
);
	initial
	begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
	end
	task step(input logic m, input logic d, output logic q);
	begin
		tms_out = m; // set in the low phase, steady at the rise
		tdi_out = d;
		#399 q = tdo_in;
		#1 tck_out = 1'b1;
		#400 tck_out = 1'b0;
	end
	endtask
	task to_idle;
		logic q;
	begin
		repeat (5) step(1'b1, ~tdi_out, q);
		step(1'b0, ~tdi_out, q);
	end
	endtask
	task scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
		logic q;
		int i;
	begin
		dout = '0;
		step(1'b1, ~tdi_out, q); // walks the standard graph from idle
		if (ir)
			step(1'b1, ~tdi_out, q);
		step(1'b0, ~tdi_out, q);
		step(1'b0, ~tdi_out, q);
		for (i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, ~tdi_out, q);
		step(1'b0, ~tdi_out, q);
		#800;
	end
	endtask
	task load(input logic [3:0] c, output logic [3:0] cap);
		logic [127:0] o;
	begin
		scan(1'b1, 4, {124'h0, (c == 4'h3) ? 4'hf : c}, o); // production-only code never sent
		cap = o[3:0];
	end
	endtask
endmodule

//--- verif/jtdr_top_bench.sv
// Purpose: self-checking bench for the test data registers
// Assumes: host model drives tck, tms and tdi; the bench drives test reset
// Notes: expected values queued beside seen values, compared by a monitor
`timescale 1ns/1ps
module jtdr_top_bench;
	localparam logic [3:0] VER = 4'ha; // arbitrary
	localparam logic [15:0] PART = 16'h5a3c; // arbitrary
	localparam logic [10:0] MAKER = 11'h2b1; // arbitrary
	logic clk = 1'b0, rst = 1'b1, trst_n = 1'b0, ext_in = 1'b0;
	wire tck, tms, tdi, tdo, oe, ext_out, ph1, ph2, clamp, resync, c2_upd;
	wire [3:0] chain, ir, st;
	logic [51:0] c0_sys = '0;
	logic [52:0] c0_core = '0;
	logic [32:0] c1_sys = '0;
	wire [51:0] c0_core_out;
	wire [52:0] c0_sys_out;
	wire [32:0] c1_core;
	wire [37:0] c2_data;
	int seed, compares, mismatches, resyncs, k;
	logic [127:0] q_exp[$], q_seen[$], e, s, o, d;
	string q_nm[$], nm;
	logic [3:0] cap;
	logic [3:0] codes [5] = '{4'hf, 4'h9, 4'h4, 4'h6, 4'h7};
	always #50 clk = ~clk;
	always @(posedge clk) if (resync === 1'b1) resyncs <= resyncs + 1;
	jtdr_top #(.C0_IN(52), .VERSION(VER), .PART_NUMBER(PART), .MAKER_ID(MAKER)) u_dut (
		.CORE_CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .TCK_IN(tck), .TMS_IN(tms), .TDI_IN(tdi),
		.TEST_RESET_N_IN(trst_n), .TDO_OUT(tdo), .TDO_OE_OUT(oe), .EXT_CHAIN_SERIAL_IN_IN(ext_in),
		.EXT_CHAIN_SERIAL_OUT_OUT(ext_out), .ACTIVE_CHAIN_NUMBER_OUT(chain), .CURRENT_INSTRUCTION_OUT(ir),
		.CONTROLLER_STATE_OUT(st), .TEST_CLOCK_PHASE_ONE_OUT(ph1), .TEST_CLOCK_PHASE_TWO_OUT(ph2),
		.CLAMP_OUTPUTS_DISABLED_OUT(clamp), .RESYNC_REQUEST_OUT(resync), .C0_SYS_IN(c0_sys),
		.C0_CORE_IN(c0_core), .C0_CORE_OUT(c0_core_out), .C0_SYS_OUT(c0_sys_out), .C1_SYS_IN(c1_sys),
		.C1_CORE_OUT(c1_core), .C2_DATA_OUT(c2_data), .C2_UPDATE_OUT(c2_upd));
	jtdr_host u_host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo));
	function logic [127:0] rnd;
		rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
	endfunction
	task note(input string n, input logic [127:0] x, input logic [127:0] y);
	begin
		q_nm.push_back(n);
		q_exp.push_back(x);
		q_seen.push_back(y);
	end
	endtask
	task close_out;
	begin
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	task sel(input logic [3:0] ch);
	begin
		u_host.load(4'h2, cap);
		u_host.scan(1'b0, 4, {124'h0, ch}, o);
		note("chsel_cap", 4'h8, o[3:0]);
		note("chain", ch, chain);
		u_host.load(4'hc, cap);
		note("chain_kept", ch, chain);
	end
	endtask
	initial
	forever
	begin
		wait (q_seen.size() != 0);
		nm = q_nm.pop_front();
		e = q_exp.pop_front();
		s = q_seen.pop_front();
		compares++;
		if (e !== s)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	end
	initial
	begin
		#2000000;
		mismatches++;
		close_out;
	end
	initial
	begin
		seed = 9;
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		trst_n = 1'b1;
		repeat (3) @(negedge clk);
		note("ir", 4'he, ir);
		note("chain", 4'h3, chain);
		note("state", 4'hf, st);
		u_host.to_idle;
		u_host.scan(1'b0, 32, rnd(), o);
		note("id", {VER, PART, MAKER, 1'b1}, o[31:0]);
		note("tdo_oe", 1'b0, oe);
		for (k = 0; k < 5; k++)
		begin
			u_host.load(codes[k], cap);
			note("ir_cap", 4'h1, cap);
			note("ir", codes[k], ir);
			note("clamp", codes[k] == 4'h9 || codes[k] == 4'h7, clamp);
			d = rnd();
			u_host.scan(1'b0, 8, d, o);
			note("bypass", {d[6:0], 1'b0}, o[7:0]);
		end
		note("resync", 1'b1, resyncs != 0);
		sel(4'h0);
		@(negedge clk);
		d = rnd();
		c0_sys = d[51:0];
		c0_core = d[104:52];
		c1_sys = d[127:95];
		d = rnd();
		u_host.scan(1'b0, 105, d, o);
		note("chain0", {c0_core, c0_sys}, o[104:0]);
		note("core_in", d[51:0], c0_core_out);
		note("sys_out", c0_core, c0_sys_out);
		sel(4'h1);
		u_host.scan(1'b0, 33, d, o);
		note("chain1", c1_sys, o[32:0]);
		note("core_in1", d[32:0], c1_core);
		sel(4'h2);
		u_host.scan(1'b0, 38, d, o);
		note("chain2", d[37:0], c2_data);
		for (k = 3; k < 6; k += 2)
		begin
			sel(k[3:0]);
			@(negedge clk);
			ext_in = (k == 3);
			u_host.scan(1'b0, 8, rnd(), o);
			note("ext", (k == 3) ? 8'hff : 8'h00, o[7:0]);
			note("ext_out", tdi, ext_out);
		end
		@(negedge clk);
		trst_n = 1'b0;
		repeat (10) @(negedge clk);
		trst_n = 1'b1;
		note("chain", 4'h3, chain);
		note("ir", 4'he, ir);
		#1;
		close_out;
	end
endmodule
